//--- hw/dpt_params.svh
/*
  Constants of the dual down timer: register offsets, field positions,
  reset values and timing counts.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef DPT_PARAMS_SVH
`define DPT_PARAMS_SVH

// =====================================================================
// Register byte offsets
`define DPT_OFS_CFG      8'h00
`define DPT_OFS_CH0      8'h04
`define DPT_OFS_CH1      8'h08
`define DPT_OFS_RLD0     8'h0c
`define DPT_OFS_RLD1     8'h10
`define DPT_OFS_CNT0     8'h14
`define DPT_OFS_CNT1     8'h18
`define DPT_OFS_FLAG     8'h1c

// =====================================================================
// Shared configuration fields
`define DPT_CFG_WIDE     4
`define DPT_CFG_TSEL     3
`define DPT_CFG_TEN      2
`define DPT_CFG_SRC1     1
`define DPT_CFG_SRC0     0

// =====================================================================
// Channel control fields
`define DPT_CH_EVC       7
`define DPT_CH_FSEL      6
`define DPT_CH_POL       5
`define DPT_CH_PSC_HI    4
`define DPT_CH_PSC_LO    3
`define DPT_CH_CONT      2
`define DPT_CH_PRESET    1
`define DPT_CH_RUN       0

// =====================================================================
// Flag fields
`define DPT_FLAG0        0
`define DPT_FLAG1        1

// =====================================================================
// Reset values
`define DPT_RLD_RST      8'hff
`define DPT_CNT_RST      8'hff

// =====================================================================
// Prescale masks: divide by 1, 4, 16, 64
`define DPT_MASK_DIV1    6'h00
`define DPT_MASK_DIV4    6'h03
`define DPT_MASK_DIV16   6'h0f
`define DPT_MASK_DIV64   6'h3f

// =====================================================================
// Noise filter: falling tick edges before a level is accepted
`define DPT_FILT_EDGES   2'h2

`endif

//--- hw/dpt_pkg.sv
/*
  Types of the dual down timer: the whole state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dpt_pkg;

  typedef struct packed {
    logic        wide;
    logic        tsel;
    logic        ten;
    logic        src0;
    logic        src1;
    logic        evc;
    logic        fsel;
    logic        pol;
    logic [1:0]  psc0;
    logic        ch0_continuous_select;
    logic        run0;
    logic [1:0]  psc1;
    logic        ch1_continuous_select;
    logic        run1;
    logic [7:0]  rld0;
    logic [7:0]  rld1;
    logic [7:0]  cnt0;
    logic [7:0]  cnt1;
    logic [5:0]  pre0;
    logic [5:0]  pre1;
    logic        flag0;
    logic        flag1;
    logic        slow_q;
    logic        fast_q;
    logic        tick_q;
    logic        evp;
    logic        filt;
    logic [1:0]  fcnt;
    logic        tog;
    logic        pin;
    logic        uf0_out;
    logic        uf1_out;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dpt_state_t;

endpackage

//--- hw/dpt_timer.sv
/*
  Dual 8-bit programmable down timer with 16-bit cascade, event
  counting, noise filter and pulse width measurement; APB slave.
  Assumes oscillator, tick and event inputs synchronous to pclk.
*/
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dpt_params.svh"

// Notes on behaviour
// - Preset strobe loads counter from reload value
// - Run bit starts counting; clear halts it
// - Start and stop keep counter contents
// - Counts readable anytime through readback registers
// - Underflow reloads, sets flag, pulses underflow output
// - Continuous mode reloads and keeps counting
// - One-shot underflow reloads, stops, clears run
// - Rewriting run starts another single countdown
// - Narrow mode: channels fully independent
// - Wide mode: cascade, channel 0 controls, run1 zero
// - Source select: slow when zero, fast when one
// - Prescale codes divide by 1, 4, 16, 64
// - Wide mode uses channel 0 prescale only
// - Source reaches prescaler only while running
// - Event select: channel 0 counts input edges
// - Polarity picks falling or rising event edge
// - Filter accepts level at second tick fall
// - Pulse mode counts only during measured level
// - Polarity picks low or high level measured
// - Wide pulse mode is one 16-bit measurer
// - Toggle output flips on each selected underflow
// - Wide mode never sets channel 0 flag
module dpt_timer
  import dpt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        slow_oscillator,
  input  wire logic        fast_oscillator,
  input  wire logic        tick_2048hz,
  input  wire logic        event_input_pin,
  output logic             toggle_output_pin,
  output logic             ch0_underflow,
  output logic             ch1_underflow
);

  // ===================================================================
  // Helpers
  function automatic logic [5:0] ratio_mask(input logic [1:0] code);
    logic [5:0] m;
    m = `DPT_MASK_DIV1;
    unique case (code)
      2'b00: m = `DPT_MASK_DIV1;
      2'b01: m = `DPT_MASK_DIV4;
      2'b10: m = `DPT_MASK_DIV16;
      2'b11: m = `DPT_MASK_DIV64;
    endcase
    return m;
  endfunction

  function automatic logic src_edge(input logic sel, input logic slow_rise,
                                    input logic fast_rise);
    return sel ? fast_rise : slow_rise;
  endfunction

  // ===================================================================
  // State
  dpt_state_t st_r;
  dpt_state_t st_nxt;

  logic wr_ack;
  logic wr_ch0;
  logic dec0;
  logic dec1;
  logic uf0;
  logic uf1;
  logic uf_lo;
  logic tick0;
  logic tick1;

  // ===================================================================
  // Next state
  always_comb
  begin
    logic slow_rise;
    logic fast_rise;
    logic tick_fall;
    logic ev_sig;
    logic ev_edge;
    logic [5:0] m0;
    logic [5:0] m1;
    logic tsel_uf;
    slow_rise = 1'b0;
    fast_rise = 1'b0;
    tick_fall = 1'b0;
    ev_sig    = 1'b0;
    ev_edge   = 1'b0;
    m0        = 6'h00;
    m1        = 6'h00;
    tsel_uf   = 1'b0;
    st_nxt    = st_r;

    slow_rise = slow_oscillator & ~st_r.slow_q;
    fast_rise = fast_oscillator & ~st_r.fast_q;
    tick_fall = st_r.tick_q & ~tick_2048hz;
    st_nxt.slow_q = slow_oscillator;
    st_nxt.fast_q = fast_oscillator;
    st_nxt.tick_q = tick_2048hz;

    // Noise filter on event input
    if (event_input_pin == st_r.filt)
    begin
      st_nxt.fcnt = 2'h0;
    end
    else if (tick_fall)
    begin
      if (st_r.fcnt + 2'h1 == `DPT_FILT_EDGES)
      begin
        st_nxt.filt = event_input_pin;
        st_nxt.fcnt = 2'h0;
      end
      else
      begin
        st_nxt.fcnt = st_r.fcnt + 2'h1;
      end
    end
    ev_sig = st_r.fsel ? st_r.filt : event_input_pin;
    st_nxt.evp = ev_sig;
    ev_edge = st_r.pol ? (ev_sig & ~st_r.evp) : (~ev_sig & st_r.evp);

    // Prescalers, source gated by run
    m0 = ratio_mask(st_r.psc0);
    m1 = ratio_mask(st_r.psc1);
    tick0 = 1'b0;
    tick1 = 1'b0;
    if (!st_r.run0)
    begin
      st_nxt.pre0 = 6'h00;
    end
    else if (src_edge(st_r.src0, slow_rise, fast_rise))
    begin
      tick0 = (st_r.pre0 & m0) == m0;
      st_nxt.pre0 = tick0 ? 6'h00 : st_r.pre0 + 6'h01;
    end
    if (!st_r.run1 || st_r.wide)
    begin
      st_nxt.pre1 = 6'h00;
    end
    else if (src_edge(st_r.src1, slow_rise, fast_rise))
    begin
      tick1 = (st_r.pre1 & m1) == m1;
      st_nxt.pre1 = tick1 ? 6'h00 : st_r.pre1 + 6'h01;
    end

    // Channel 0 decrement source
    if (st_r.evc)
    begin
      dec0 = st_r.run0 & ev_edge;
    end
    else if (st_r.fsel)
    begin
      dec0 = tick0 & (event_input_pin == st_r.pol);
    end
    else
    begin
      dec0 = tick0;
    end
    uf_lo = dec0 && st_r.cnt0 == 8'h00;
    dec1  = st_r.wide ? uf_lo : tick1;
    uf0   = uf_lo && !st_r.wide;
    uf1   = dec1 && st_r.cnt1 == 8'h00;

    // Counters
    if (dec0)
    begin
      st_nxt.cnt0 = uf_lo ? st_r.rld0 : st_r.cnt0 - 8'h01;
    end
    if (dec1)
    begin
      st_nxt.cnt1 = uf1 ? st_r.rld1 : st_r.cnt1 - 8'h01;
    end
    if (uf0 && !st_r.ch0_continuous_select)
    begin
      st_nxt.run0 = 1'b0;
    end
    if (uf1 && st_r.wide && !st_r.ch0_continuous_select)
    begin
      st_nxt.run0 = 1'b0;
    end
    if (uf1 && !st_r.wide && !st_r.ch1_continuous_select)
    begin
      st_nxt.run1 = 1'b0;
    end

    // Underflow effects
    st_nxt.uf0_out = uf0;
    st_nxt.uf1_out = uf1;
    tsel_uf = (st_r.wide || st_r.tsel) ? uf1 : uf0;
    if (tsel_uf)
    begin
      st_nxt.tog = ~st_r.tog;
    end

    // APB: no wait states, answer registered
    wr_ack = psel & penable & pwrite & st_r.pready;
    wr_ch0 = wr_ack && paddr == `DPT_OFS_CH0;
    if (wr_ack)
    begin
      unique case (paddr)
        `DPT_OFS_CFG:
        begin
          st_nxt.wide = pwdata[`DPT_CFG_WIDE];
          st_nxt.tsel = pwdata[`DPT_CFG_TSEL];
          st_nxt.ten  = pwdata[`DPT_CFG_TEN];
          st_nxt.src1 = pwdata[`DPT_CFG_SRC1];
          st_nxt.src0 = pwdata[`DPT_CFG_SRC0];
        end
        `DPT_OFS_CH0:
        begin
          st_nxt.evc   = pwdata[`DPT_CH_EVC];
          st_nxt.fsel  = pwdata[`DPT_CH_FSEL];
          st_nxt.pol   = pwdata[`DPT_CH_POL];
          st_nxt.psc0  = pwdata[`DPT_CH_PSC_HI:`DPT_CH_PSC_LO];
          st_nxt.ch0_continuous_select = pwdata[`DPT_CH_CONT];
          st_nxt.run0  = pwdata[`DPT_CH_RUN];
          if (pwdata[`DPT_CH_PRESET])
          begin
            st_nxt.cnt0 = st_r.rld0;
          end
        end
        `DPT_OFS_CH1:
        begin
          st_nxt.psc1  = pwdata[`DPT_CH_PSC_HI:`DPT_CH_PSC_LO];
          st_nxt.ch1_continuous_select = pwdata[`DPT_CH_CONT];
          st_nxt.run1  = pwdata[`DPT_CH_RUN];
          if (pwdata[`DPT_CH_PRESET])
          begin
            st_nxt.cnt1 = st_r.rld1;
          end
        end
        `DPT_OFS_RLD0: st_nxt.rld0 = pwdata[7:0];
        `DPT_OFS_RLD1: st_nxt.rld1 = pwdata[7:0];
        default: ;
      endcase
    end

    // Flags: set wins over write-one clear
    if (wr_ack && paddr == `DPT_OFS_FLAG)
    begin
      if (pwdata[`DPT_FLAG0])
      begin
        st_nxt.flag0 = 1'b0;
      end
      if (pwdata[`DPT_FLAG1])
      begin
        st_nxt.flag1 = 1'b0;
      end
    end
    if (uf0)
    begin
      st_nxt.flag0 = 1'b1;
    end
    if (uf1)
    begin
      st_nxt.flag1 = 1'b1;
    end
    if (st_nxt.wide)
    begin
      st_nxt.run1 = 1'b0;
    end

    st_nxt.pin = st_nxt.ten ? st_nxt.tog : 1'b1;

    st_nxt.pready  = psel & ~penable;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = 32'h0000_0000;
    if (psel && !penable)
    begin
      unique case (paddr)
        `DPT_OFS_CFG:
          st_nxt.prdata[4:0] = {st_r.wide, st_r.tsel, st_r.ten, st_r.src1, st_r.src0};
        `DPT_OFS_CH0:
          st_nxt.prdata[7:0] = {st_r.evc, st_r.fsel, st_r.pol, st_r.psc0,
                                st_r.ch0_continuous_select, 1'b0, st_r.run0};
        `DPT_OFS_CH1:
          st_nxt.prdata[4:0] = {st_r.psc1, st_r.ch1_continuous_select, 1'b0, st_r.run1};
        `DPT_OFS_RLD0: st_nxt.prdata[7:0] = st_r.rld0;
        `DPT_OFS_RLD1: st_nxt.prdata[7:0] = st_r.rld1;
        `DPT_OFS_CNT0: st_nxt.prdata[7:0] = st_r.cnt0;
        `DPT_OFS_CNT1: st_nxt.prdata[7:0] = st_r.cnt1;
        `DPT_OFS_FLAG: st_nxt.prdata[1:0] = {st_r.flag1, st_r.flag0};
        default:       st_nxt.pslverr = 1'b1;
      endcase
    end
  end

  // ===================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r      <= '0;
      st_r.rld0 <= `DPT_RLD_RST;
      st_r.rld1 <= `DPT_RLD_RST;
      st_r.cnt0 <= `DPT_CNT_RST;
      st_r.cnt1 <= `DPT_CNT_RST;
      st_r.pin  <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pready            = st_r.pready;
  assign pslverr           = st_r.pslverr;
  assign prdata            = st_r.prdata;
  assign toggle_output_pin = st_r.pin;
  assign ch0_underflow     = st_r.uf0_out;
  assign ch1_underflow     = st_r.uf1_out;

  // ===================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_setup;
    psel && !penable && !pwrite && paddr == `DPT_OFS_CNT0;
  endsequence

  sequence s_preset0;
    wr_ch0 && pwdata[`DPT_CH_PRESET];
  endsequence

  a_preset_load: assert property (s_preset0 |=> st_r.cnt0 == $past(st_r.rld0))
    else $error("preset did not load channel 0");

  a_stop_hold: assert property (!st_r.run0 && !wr_ch0 |=> $stable(st_r.cnt0))
    else $error("stopped counter changed");

  a_readback: assert property (s_read_setup ##1 psel && penable |->
    prdata[7:0] == $past(st_r.cnt0))
    else $error("count readback wrong");

  a_reload_uf: assert property (uf0 && !wr_ch0 |=>
    st_r.cnt0 == $past(st_r.rld0) && ch0_underflow)
    else $error("underflow did not reload");

  a_cont_keep: assert property (uf0 && st_r.ch0_continuous_select && !wr_ch0 |=> st_r.run0)
    else $error("continuous mode stopped");

  a_oneshot_stop: assert property (uf0 && !st_r.ch0_continuous_select && !wr_ch0 |=> !st_r.run0)
    else $error("one-shot did not stop");

  a_wide_run1: assert property (st_r.wide |-> !st_r.run1)
    else $error("channel 1 run set in wide mode");

  a_no_flag0: assert property (st_r.wide && !st_r.flag0 |=> !st_r.flag0)
    else $error("channel 0 flag set in wide mode");

  a_toggle_flip: assert property (uf1 && st_r.wide |=> st_r.tog != $past(st_r.tog))
    else $error("toggle did not flip");

endmodule
`default_nettype wire

//--- sim/dpt_event_src.sv
/*
  Model of the external event source on the timer's input pin.
  Assumes a one-cycle start pulse from the bench, synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dpt_event_src
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [7:0] n_pulses,
  input  wire logic [7:0] half_len,
  output logic            pin,
  output logic            busy
);
  logic [8:0] edges_r;
  logic [7:0] tmr_r;
  // ==========================
  // Pulse train, idle low
  assign busy = (edges_r != 9'h000);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      edges_r <= 9'h000;
      tmr_r   <= 8'h00;
      pin     <= 1'b0;
    end
    else if (start)
    begin
      edges_r <= {n_pulses, 1'b0};
      tmr_r   <= half_len;
    end
    else if (busy && tmr_r <= 8'h01)
    begin
      pin     <= ~pin;  // Each level held half_len cycles
      edges_r <= edges_r - 9'h001;
      tmr_r   <= half_len;
    end
    else if (busy)
      tmr_r <= tmr_r - 8'h01;
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
/*
  Self-checking bench of the dual down timer over APB.
  Assumes the timer's package and header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpt_params.svh"
module tb_top;
  typedef struct packed {logic ch; logic src; logic [1:0] psc; logic [7:0] rld;} dpt_row_t;
  logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, ev_n = 8'h00, ev_len = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, hv;
  logic        pready, pslverr, tog, uf0, uf1, e, tg, ev_pin, ev_busy;
  logic        slow = 1'b0, fast = 1'b0, tick = 1'b0, ev_go = 1'b0;
  logic [2:0]  dv = 3'h0;
  int          n_fail = 0, check_count = 0, cyc = 0, n_uf0 = 0, t0, t1, u;
  dpt_row_t    rw;
  dpt_row_t    rows [6] = '{'{1'b0, 1'b1, 2'h0, 8'h03}, '{1'b0, 1'b1, 2'h1, 8'h02},
    '{1'b0, 1'b1, 2'h2, 8'h01}, '{1'b0, 1'b0, 2'h3, 8'h00}, '{1'b1, 1'b1, 2'h1, 8'h04},
    '{1'b1, 1'b0, 2'h0, 8'h05}};

  dpt_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .slow_oscillator(slow), .fast_oscillator(fast), .tick_2048hz(tick),
    .event_input_pin(ev_pin), .toggle_output_pin(tog), .ch0_underflow(uf0),
    .ch1_underflow(uf1));
  dpt_event_src src_model (.pclk(pclk), .presetn(presetn), .start(ev_go),
    .n_pulses(ev_n), .half_len(ev_len), .pin(ev_pin), .busy(ev_busy));

  // ==========================
  // Clocks and timeout
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    dv <= dv + 3'h1;
    fast <= ~fast;
    if (dv[1:0] == 2'h3) slow <= ~slow;
    if (dv == 3'h7) tick <= ~tick;
    if (uf0 === 1'b1) n_uf0 <= n_uf0 + 1;
    if (cyc == 60000)
    begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================
  // Tasks
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_uf(input logic ch, output int t);
    int k;
    k = 0;
    @(posedge pclk);
    while ((ch ? uf1 : uf0) !== 1'b1 && k < 4000)
    begin
      @(posedge pclk);
      k++;
    end
    t = cyc;
    check("underflow seen", {31'h0, k < 4000}, 32'h1);
  endtask
  task automatic pulses(input logic [7:0] n, input logic [7:0] len);
    ev_n <= n;
    ev_len <= len;
    ev_go <= 1'b1;
    @(posedge pclk);
    ev_go <= 1'b0;
    @(posedge pclk);
    while (ev_busy === 1'b1)
    begin
      @(posedge pclk);
    end
    repeat (40) @(posedge pclk);
  endtask

  // ==========================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DPT_OFS_RLD0);
    check("rld0", r, 32'hff);
    rd(`DPT_OFS_CNT1);
    check("cnt1", r, 32'hff);
    rd(8'h20);
    check("slverr", {31'h0, e}, 32'h1);
    foreach (rows[i])
    begin
      rw = rows[i];
      wr(`DPT_OFS_CFG, {27'h0, 1'b0, rw.ch, 1'b1, rw.src, rw.src});
      wr(rw.ch ? `DPT_OFS_RLD1 : `DPT_OFS_RLD0, {24'h0, rw.rld});
      wr(rw.ch ? `DPT_OFS_CH1 : `DPT_OFS_CH0, {27'h0, rw.psc, 3'h7});
      wait_uf(rw.ch, t0);
      repeat (2) @(posedge pclk);
      tg = tog;
      wait_uf(rw.ch, t1);
      check("interval", t1 - t0,
        (rw.rld + 1) * (1 << (2 * rw.psc)) * (rw.src ? 2 : 8));
      repeat (2) @(posedge pclk);
      check("toggle", {31'h0, tog}, {31'h0, ~tg});
      wr(rw.ch ? `DPT_OFS_CH1 : `DPT_OFS_CH0, 32'h0);
      rd(`DPT_OFS_FLAG);
      check("flag", r, rw.ch ? 32'h2 : 32'h1);
      wr(`DPT_OFS_FLAG, 32'h3);
    end
    wr(`DPT_OFS_CFG, 32'h3);
    wr(`DPT_OFS_RLD0, 32'h5c);
    wr(`DPT_OFS_CH0, 32'h2);
    repeat (20) @(posedge pclk);
    rd(`DPT_OFS_CNT0);
    check("preset", r, 32'h5c);
    wr(`DPT_OFS_CH0, 32'h1);
    repeat (20) @(posedge pclk);
    wr(`DPT_OFS_CH0, 32'h0);
    rd(`DPT_OFS_CNT0);
    hv = r;
    repeat (20) @(posedge pclk);
    rd(`DPT_OFS_CNT0);
    check("held", r, hv);
    check("counted", {31'h0, hv < 32'h5c && hv > 32'h40}, 32'h1);
    wr(`DPT_OFS_RLD0, 32'h2);
    wr(`DPT_OFS_CH0, 32'h3);
    wait_uf(1'b0, t0);
    repeat (4) @(posedge pclk);
    rd(`DPT_OFS_CH0);
    check("oneshot run", r, 32'h0);
    rd(`DPT_OFS_CNT0);
    check("oneshot cnt", r, 32'h2);
    wr(`DPT_OFS_CH0, 32'h1);
    wait_uf(1'b0, t1);
    wr(`DPT_OFS_FLAG, 32'h3);
    wr(`DPT_OFS_CFG, 32'h11);
    wr(`DPT_OFS_RLD0, 32'h1);
    wr(`DPT_OFS_RLD1, 32'h1);
    wr(`DPT_OFS_CH1, 32'h19);
    wr(`DPT_OFS_CH0, 32'h7);
    u = n_uf0;
    wait_uf(1'b1, t0);
    wait_uf(1'b1, t1);
    check("wide interval", t1 - t0, 32'h8);
    rd(`DPT_OFS_CH1);
    check("wide run1", r & 32'h1, 32'h0);
    wr(`DPT_OFS_CH0, 32'h0);
    rd(`DPT_OFS_FLAG);
    check("wide flag", r, 32'h2);
    check("wide uf0", n_uf0 - u, 32'h0);
    wr(`DPT_OFS_FLAG, 32'h3);
    wr(`DPT_OFS_CFG, 32'h1);
    wr(`DPT_OFS_RLD0, 32'hff);
    for (int p = 0; p < 2; p++)
    begin
      wr(`DPT_OFS_CH0, 32'h9b | (p << 5));
      pulses(8'h3, 8'h6);
      rd(`DPT_OFS_CNT0);
      check("events", r, 32'hfc);
    end
    wr(`DPT_OFS_CH0, 32'hdb);
    pulses(8'h3, 8'h3);
    rd(`DPT_OFS_CNT0);
    check("filter short", r, 32'hff);
    pulses(8'h2, 8'h28);
    rd(`DPT_OFS_CNT0);
    check("filter long", r, 32'hfd);
    wr(`DPT_OFS_CH0, 32'h63);
    repeat (20) @(posedge pclk);
    rd(`DPT_OFS_CNT0);
    check("pw idle", r, 32'hff);
    pulses(8'h1, 8'h28);
    rd(`DPT_OFS_CNT0);
    check("pw width", {31'h0, r >= 32'he9 && r <= 32'hec}, 32'h1);
    // Mid-run reset while channel 0 is running
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("reset pin", {31'h0, tog}, 32'h1);
    check("reset uf", {30'h0, uf1, uf0}, 32'h0);
    presetn <= 1'b1;
    rd(`DPT_OFS_CNT0);
    check("reset cnt0", r, 32'hff);
    rd(`DPT_OFS_CH0);
    check("reset run0", r, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
